/* File: inc/dtm_pkg.sv */
package dtm_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 200;
  localparam int MS_CYCLES = CLK_MHZ * 1000;
  localparam int KEYPAD_LOSS_MS = 2000;
  localparam int OLT_150_MS = 60000;
  localparam int OLT_200_MS = 500;
  localparam int OLT_RATE_200 = OLT_150_MS / OLT_200_MS;

  // Terminal and selection codes
  localparam int NUM_MF = 11;
  localparam int NUM_OPT = 3;
  localparam logic [3:0] MF_EXT_TRIP = 4'h3;
  localparam logic [3:0] MF_BLOCK = 4'h4;
  localparam int PL_OUT_BIT = 1;
  localparam int PL_IN_BIT = 2;

  // Register byte addresses
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_CFG = 6'h04;
  localparam logic [5:0] ADDR_OVERSPEED = 6'h08;
  localparam logic [5:0] ADDR_ENC_TIME = 6'h0c;
  localparam logic [5:0] ADDR_PID_TIME = 6'h10;
  localparam logic [5:0] ADDR_MF_LO = 6'h14;
  localparam logic [5:0] ADDR_MF_HI = 6'h18;
  localparam logic [5:0] ADDR_TRIPS = 6'h1c;
  localparam logic [5:0] ADDR_LAST = 6'h20;
  localparam int CTRL_RESET_BIT = 0;

  // Reset values
  localparam logic [15:0] OVERSPEED_RST = 16'hffff;
  localparam logic [15:0] ENC_TIME_RST = 16'h03e8;
  localparam logic [15:0] PID_TIME_RST = 16'h03e8;

  // Trip indices
  localparam int T_OVER_LOAD = 0;
  localparam int T_UNDER_LOAD = 1;
  localparam int T_OVER_CURRENT = 2;
  localparam int T_OVER_VOLT = 3;
  localparam int T_LOW_VOLT = 4;
  localparam int T_ETHERMAL = 5;
  localparam int T_OUT_PHASE = 6;
  localparam int T_IN_PHASE = 7;
  localparam int T_DRIVE_OLT = 8;
  localparam int T_EXT_TRIP = 9;
  localparam int T_BLOCK = 10;
  localparam int T_HW_DIAG = 11;
  localparam int T_FAN = 12;
  localparam int T_OVERSPEED = 13;
  localparam int T_SPEED_DEV = 14;
  localparam int T_ENCODER = 15;
  localparam int T_PRE_PID = 16;
  localparam int T_LOST_KEYPAD = 17;
  localparam int T_LOST_CMD = 18;
  localparam int T_OPT1 = 19;
  localparam int NUM_TRIPS = 22;

  typedef logic [NUM_TRIPS-1:0] dtm_trips_t;

  // Clearing policy per trip
  localparam dtm_trips_t FATAL_MASK = NUM_TRIPS'(1) << T_HW_DIAG;
  localparam dtm_trips_t LEVEL_MASK = (NUM_TRIPS'(1) << T_LOW_VOLT) | (NUM_TRIPS'(1) << T_BLOCK)
    | (NUM_TRIPS'(1) << T_LOST_KEYPAD) | (NUM_TRIPS'(1) << T_LOST_CMD)
    | (NUM_TRIPS'(7) << T_OPT1);
  localparam dtm_trips_t LATCH_MASK = ~(FATAL_MASK | LEVEL_MASK);

  // Conditions from the power stage and feedback
  typedef struct packed {
    logic over_current;
    logic bus_under;
    logic bus_over;
    logic out_phase_loss;
    logic in_phase_loss;
    logic cur_above_150;
    logic cur_above_200;
    logic motor_overload;
    logic motor_underload;
    logic thermal_over;
    logic fan_fault;
    logic speed_dev;
    logic encoder_abn;
    logic keypad_link_ok;
    logic cmd_lost;
    logic [NUM_OPT-1:0] opt_present;
    logic [NUM_OPT-1:0] opt_comm_ok;
    logic nvm_fault;
    logic adc_fault;
    logic wdog1;
    logic wdog2;
    logic pid_below;
    logic pre_pid_run;
  } dtm_sense_t;

  // Protection settings word
  typedef struct packed {
    logic keypad_is_source;
    logic encoder_wire_check;
    logic speed_deviation_select;
    logic thermal_trip_select;
    logic underload_trip_select;
    logic overload_trip_select;
    logic [1:0] fan_trip_mode;
    logic [1:0] command_loss_mode;
    logic [1:0] keypad_loss_mode;
    logic [2:0] phase_loss_select;
  } dtm_cfg_t;
  localparam int CFG_W = $bits(dtm_cfg_t);
  localparam dtm_cfg_t CFG_RST = '0;

  // Fault history entry
  typedef struct packed {
    logic valid;
    logic [4:0] code;
  } dtm_hist_t;
endpackage : dtm_pkg

/* File: hdl/dtm_trip_manager.sv */
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Latch trips hold after cause ends; clear on fault reset once cause gone.
// - Level trips follow their cause and never enter fault history.
// - Fatal trip survives fault reset; only power-on reset clears it.
// - Output current above 200% rated raises latch overcurrent trip.
// - Low bus gives level undervoltage; high bus gives latch overvoltage.
// - Output phase loss trips only when phase-loss select bit 1 set.
// - Input phase loss trips only when phase-loss select bit 2 set.
// - Drive overload inverse-time: 1 minute at 150%, 0.5 s at 200%.
// - Keypad source, nonzero mode: keypad link loss trips after 2 s.
// - Multifunction input with code 3 is an external latch trip.
// - Memory, ADC offset or watchdog fault raises fatal diagnostic trip.
// - Motor overload trip armed only with nonzero overload select.
// - Underload trip armed only with nonzero underload select.
// - Electronic thermal trip armed only with nonzero thermal select.
// - Cooling-fan fault trips only when fan trip mode is 0.
// - Speed above overspeed level raises latch overspeed trip.
// - Speed deviation trips when deviation select is 1.
// - Encoder fault persisting set time trips when wire check is 1.
// - Each option slot: removal after fit or link loss, level trip.
// - Command loss trips as level when command-loss mode nonzero.
// - Pre-PID feedback continuously below setting raises latch trip.
module dtm_trip_manager #(
  parameter int P_MS_CYCLES = dtm_pkg::MS_CYCLES,
  parameter int P_OLT_LIMIT = dtm_pkg::OLT_150_MS
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire dtm_pkg::dtm_sense_t i_sense,
  input wire logic [dtm_pkg::NUM_MF-1:0] i_mf_in,
  input wire logic i_fault_reset,
  input wire logic [15:0] i_motor_speed,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output dtm_pkg::dtm_trips_t o_trips,
  output logic o_fault_held,
  output logic o_output_block,
  output dtm_pkg::dtm_hist_t o_hist
);
  import dtm_pkg::*;

  // Elaboration check on parameters
  if (P_MS_CYCLES < 1 || P_OLT_LIMIT < OLT_RATE_200) begin : g_bad_param
    $error("dtm_trip_manager: unsupported parameter values");
  end

  dtm_sense_t sense_s1_q, sense_q;
  logic [NUM_MF-1:0] mf_s1_q, mf_q;
  logic frst_s1_q, frst_q, frst_old_q;
  dtm_cfg_t cfg_q;
  logic [15:0] overspeed_q, enc_time_q, pid_time_q;
  logic [NUM_MF-1:0][3:0] mf_sel_q;
  logic [31:0] ms_cnt_q, olt_q, kp_cnt_q, enc_cnt_q, pid_cnt_q;
  logic ms_tick;
  logic [NUM_OPT-1:0] opt_seen_q;
  dtm_trips_t cause, trips_q, trip_d, new_hist;
  logic wr_ok, reset_evt, kp_lost, enc_bad, pid_bad;
  logic [31:0] rd_d;

  // Saturating millisecond counter step
  function automatic logic [31:0] ms_step(input logic [31:0] cnt, input logic run,
                                          input logic tick);
    if (!run) begin
      ms_step = '0;
    end else if (tick && cnt != '1) begin
      ms_step = cnt + 32'h1;
    end else begin
      ms_step = cnt;
    end
  endfunction : ms_step

  // Lowest set trip index
  function automatic logic [4:0] first_set(input dtm_trips_t v);
    first_set = '0;
    for (int i = NUM_TRIPS - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction : first_set

  // Two-flop synchronisers for pins
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sense_s1_q <= '0;
      sense_q <= '0;
      mf_s1_q <= '0;
      mf_q <= '0;
      frst_s1_q <= 1'b0;
      frst_q <= 1'b0;
      frst_old_q <= 1'b0;
    end else begin
      sense_s1_q <= i_sense;
      sense_q <= sense_s1_q;
      mf_s1_q <= i_mf_in;
      mf_q <= mf_s1_q;
      frst_s1_q <= i_fault_reset;
      frst_q <= frst_s1_q;
      frst_old_q <= frst_q;
    end
  end

  // Bus handshake: one wait cycle, then a single ready cycle
  assign wr_ok = i_avs_write && !o_avs_waitrequest;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= '0;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
      if (o_avs_waitrequest) begin
        o_avs_readdata <= rd_d;
      end
    end
  end

  // Read decode; unmapped reads as zero
  always_comb begin
    rd_d = '0;
    unique case (i_avs_address)
      ADDR_CFG: rd_d = 32'(cfg_q);
      ADDR_OVERSPEED: rd_d = 32'(overspeed_q);
      ADDR_ENC_TIME: rd_d = 32'(enc_time_q);
      ADDR_PID_TIME: rd_d = 32'(pid_time_q);
      ADDR_MF_LO: rd_d = mf_sel_q[7:0];
      ADDR_MF_HI: rd_d = 32'(mf_sel_q[NUM_MF-1:8]);
      ADDR_TRIPS: rd_d = 32'(trips_q);
      ADDR_LAST: rd_d = 32'(o_hist.code);
      default: rd_d = '0;
    endcase
  end

  // Setting registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cfg_q <= CFG_RST;
      overspeed_q <= OVERSPEED_RST;
      enc_time_q <= ENC_TIME_RST;
      pid_time_q <= PID_TIME_RST;
      mf_sel_q <= '0;
    end else if (wr_ok) begin
      unique case (i_avs_address)
        ADDR_CFG: cfg_q <= dtm_cfg_t'(i_avs_writedata[CFG_W-1:0]);
        ADDR_OVERSPEED: overspeed_q <= i_avs_writedata[15:0];
        ADDR_ENC_TIME: enc_time_q <= i_avs_writedata[15:0];
        ADDR_PID_TIME: pid_time_q <= i_avs_writedata[15:0];
        ADDR_MF_LO: mf_sel_q[7:0] <= i_avs_writedata;
        ADDR_MF_HI: mf_sel_q[NUM_MF-1:8] <= i_avs_writedata[4*(NUM_MF-8)-1:0];
        default: ;
      endcase
    end
  end

  // Fault reset from pin edge or control write
  assign reset_evt = (frst_q && !frst_old_q)
    || (wr_ok && i_avs_address == ADDR_CTRL && i_avs_writedata[CTRL_RESET_BIT]);

  // Millisecond tick
  assign ms_tick = (ms_cnt_q == 32'(P_MS_CYCLES - 1));
  always_ff @(posedge i_clk) begin
    if (i_reset || ms_tick) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'h1;
    end
  end

  // Inverse-time drive overload accumulator
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      olt_q <= '0;
    end else if (ms_tick) begin
      if (sense_q.cur_above_200) begin
        olt_q <= olt_q + 32'(OLT_RATE_200);
      end else if (sense_q.cur_above_150) begin
        olt_q <= olt_q + 32'h1;
      end else if (olt_q != '0) begin
        olt_q <= olt_q - 32'h1;
      end
    end
  end

  // Persistence timers
  assign kp_lost = cfg_q.keypad_is_source && cfg_q.keypad_loss_mode != '0
    && !sense_q.keypad_link_ok;
  assign enc_bad = cfg_q.encoder_wire_check && sense_q.encoder_abn;
  assign pid_bad = sense_q.pre_pid_run && sense_q.pid_below;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      kp_cnt_q <= '0;
      enc_cnt_q <= '0;
      pid_cnt_q <= '0;
    end else begin
      kp_cnt_q <= (kp_cnt_q == 32'(KEYPAD_LOSS_MS)) && kp_lost ? kp_cnt_q
        : ms_step(kp_cnt_q, kp_lost, ms_tick);
      enc_cnt_q <= ms_step(enc_cnt_q, enc_bad, ms_tick);
      pid_cnt_q <= ms_step(pid_cnt_q, pid_bad, ms_tick);
    end
  end

  // Option fitted since power-up
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      opt_seen_q <= '0;
    end else begin
      opt_seen_q <= opt_seen_q | sense_q.opt_present;
    end
  end

  // Trip causes
  always_comb begin
    cause = '0;
    cause[T_OVER_LOAD] = cfg_q.overload_trip_select && sense_q.motor_overload;
    cause[T_UNDER_LOAD] = cfg_q.underload_trip_select && sense_q.motor_underload;
    cause[T_OVER_CURRENT] = sense_q.over_current;
    cause[T_OVER_VOLT] = sense_q.bus_over;
    cause[T_LOW_VOLT] = sense_q.bus_under;
    cause[T_ETHERMAL] = cfg_q.thermal_trip_select && sense_q.thermal_over;
    cause[T_OUT_PHASE] = cfg_q.phase_loss_select[PL_OUT_BIT] && sense_q.out_phase_loss;
    cause[T_IN_PHASE] = cfg_q.phase_loss_select[PL_IN_BIT] && sense_q.in_phase_loss;
    cause[T_DRIVE_OLT] = olt_q >= 32'(P_OLT_LIMIT);
    for (int i = 0; i < NUM_MF; i++) begin
      cause[T_EXT_TRIP] |= mf_q[i] && mf_sel_q[i] == MF_EXT_TRIP;
      cause[T_BLOCK] |= mf_q[i] && mf_sel_q[i] == MF_BLOCK;
    end
    cause[T_HW_DIAG] = sense_q.nvm_fault || sense_q.adc_fault
      || sense_q.wdog1 || sense_q.wdog2;
    cause[T_FAN] = cfg_q.fan_trip_mode == '0 && sense_q.fan_fault;
    cause[T_OVERSPEED] = i_motor_speed > overspeed_q;
    cause[T_SPEED_DEV] = cfg_q.speed_deviation_select && sense_q.speed_dev;
    cause[T_ENCODER] = enc_bad && enc_cnt_q >= 32'(enc_time_q);
    cause[T_PRE_PID] = pid_bad && pid_cnt_q >= 32'(pid_time_q);
    cause[T_LOST_KEYPAD] = kp_lost && kp_cnt_q == 32'(KEYPAD_LOSS_MS);
    cause[T_LOST_CMD] = cfg_q.command_loss_mode != '0 && sense_q.cmd_lost;
    for (int i = 0; i < NUM_OPT; i++) begin
      cause[T_OPT1 + i] = (opt_seen_q[i] && !sense_q.opt_present[i])
        || (sense_q.opt_present[i] && !sense_q.opt_comm_ok[i]);
    end
  end

  // Clearing policy: level follows, latch waits for reset, fatal holds; cause wins
  assign trip_d = (trips_q & ~LEVEL_MASK & ~(LATCH_MASK & {NUM_TRIPS{reset_evt}} & ~cause))
    | cause;
  assign new_hist = trip_d & ~trips_q & ~LEVEL_MASK;

  // Trip state and outputs
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      trips_q <= '0;
      o_fault_held <= 1'b0;
      o_output_block <= 1'b0;
    end else begin
      trips_q <= trip_d;
      o_fault_held <= |(trip_d & ~LEVEL_MASK);
      o_output_block <= |trip_d;
    end
  end
  assign o_trips = trips_q;

  // Fault history record of held trips
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_hist <= '0;
    end else begin
      o_hist.valid <= |new_hist;
      if (|new_hist) begin
        o_hist.code <= first_set(new_hist);
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_latch_reset;
    reset_evt && trips_q[T_EXT_TRIP] && !cause[T_EXT_TRIP];
  endsequence
  sequence s_block_req;
    mf_q[0] && mf_sel_q[0] == MF_BLOCK;
  endsequence

  a_latch_hold: assert property (!reset_evt |=> ((trips_q | ~$past(trips_q)) | ~LATCH_MASK) == '1)
    else $error("latch trip dropped without reset");
  a_latch_clear: assert property (s_latch_reset |=> !trips_q[T_EXT_TRIP])
    else $error("latch trip not cleared by reset");
  a_level_follow: assert property (1'b1 |=> (trips_q & LEVEL_MASK) == ($past(cause) & LEVEL_MASK))
    else $error("level trip does not follow cause");
  a_level_no_hist: assert property (o_hist.valid |-> !LEVEL_MASK[o_hist.code])
    else $error("level trip recorded in history");
  a_fatal_hold: assert property (trips_q[T_HW_DIAG] |=> trips_q[T_HW_DIAG] [*2])
    else $error("fatal trip cleared");
  a_oc_trip: assert property (sense_q.over_current |=> trips_q[T_OVER_CURRENT] && o_output_block)
    else $error("overcurrent did not trip and block");
  a_out_phase_gate: assert property (!cfg_q.phase_loss_select[PL_OUT_BIT]
    && !trips_q[T_OUT_PHASE] |=> !trips_q[T_OUT_PHASE])
    else $error("output phase trip while disarmed");
  a_keypad_wait: assert property ($rose(trips_q[T_LOST_KEYPAD]) |-> $past(kp_cnt_q) == 32'(KEYPAD_LOSS_MS))
    else $error("keypad loss trip before timeout");
  a_block_output: assert property (s_block_req |=> o_output_block && trips_q[T_BLOCK])
    else $error("block input did not block output");
  a_hw_diag: assert property ((sense_q.wdog1 || sense_q.nvm_fault) |=> trips_q[T_HW_DIAG])
    else $error("diagnostic fault did not trip");

  // Fitted option pulled out of slot 1
  sequence s_opt1_removed;
    opt_seen_q[0] && !sense_q.opt_present[0];
  endsequence

  // Class behaviour and history record
  a_fatal_survive: assert property (reset_evt && trips_q[T_HW_DIAG] |=> trips_q[T_HW_DIAG])
    else $error("fatal trip cleared by fault reset");
  a_hist_latch: assert property (o_hist.valid |-> trips_q[o_hist.code])
    else $error("history entry without held trip");
  a_held_flag: assert property (o_fault_held == |(trips_q & ~LEVEL_MASK))
    else $error("held flag disagrees with trips");

  // Power stage conditions
  a_ov_trip: assert property (sense_q.bus_over |=> trips_q[T_OVER_VOLT])
    else $error("overvoltage did not trip");
  a_uv_level: assert property (!sense_q.bus_under |=> !trips_q[T_LOW_VOLT])
    else $error("undervoltage trip without cause");
  a_in_phase_arm: assert property (!cfg_q.phase_loss_select[PL_IN_BIT] |-> !cause[T_IN_PHASE])
    else $error("input phase cause while disarmed");
  a_olt_trip: assert property (olt_q >= 32'(P_OLT_LIMIT) |=> trips_q[T_DRIVE_OLT])
    else $error("drive overload did not trip");

  // Terminals and keypad
  a_keypad_arm: assert property (!cfg_q.keypad_is_source |-> !cause[T_LOST_KEYPAD])
    else $error("keypad loss cause while not source");
  a_ext_trip: assert property (mf_q[0] && mf_sel_q[0] == MF_EXT_TRIP |=> trips_q[T_EXT_TRIP])
    else $error("external input did not trip");
  a_cmd_arm: assert property (cfg_q.command_loss_mode == '0 |-> !cause[T_LOST_CMD])
    else $error("command loss cause while disarmed");

  // Motor protection arming
  a_overload_arm: assert property (!cfg_q.overload_trip_select |-> !cause[T_OVER_LOAD])
    else $error("overload cause while disarmed");
  a_underload_arm: assert property (!cfg_q.underload_trip_select |-> !cause[T_UNDER_LOAD])
    else $error("underload cause while disarmed");
  a_thermal_arm: assert property (!cfg_q.thermal_trip_select |-> !cause[T_ETHERMAL])
    else $error("thermal cause while disarmed");
  a_fan_arm: assert property (cfg_q.fan_trip_mode != '0 |-> !cause[T_FAN])
    else $error("fan cause in warning mode");

  // Speed, encoder and process feedback
  a_overspeed: assert property (i_motor_speed > overspeed_q |=> trips_q[T_OVERSPEED])
    else $error("overspeed did not trip");
  a_dev_arm: assert property (!cfg_q.speed_deviation_select |-> !cause[T_SPEED_DEV])
    else $error("speed deviation cause while disarmed");
  a_encoder_arm: assert property (!cfg_q.encoder_wire_check |-> !cause[T_ENCODER])
    else $error("encoder cause while disarmed");
  a_pid_trip: assert property (pid_bad && pid_cnt_q >= 32'(pid_time_q) |=> trips_q[T_PRE_PID])
    else $error("pre-PID failure did not trip");

  // Option slots
  a_opt_removed: assert property (s_opt1_removed |=> trips_q[T_OPT1])
    else $error("option removal did not trip");
endmodule : dtm_trip_manager

/* File: verif/dtm_plant_model.sv */
`timescale 1ns/1ps
// Sensors, terminals and fault reset pin facing the trip manager
module dtm_plant_model (
  input wire logic i_clk,
  output dtm_pkg::dtm_sense_t o_sense,
  output logic [dtm_pkg::NUM_MF-1:0] o_mf_in,
  output logic o_fault_reset,
  output logic [15:0] o_motor_speed
);
  import dtm_pkg::*;

  // Healthy plant at power-up: links up, no faults, motor stopped
  initial begin
    o_sense = '0;
    o_sense.keypad_link_ok = 1'b1;
    o_sense.opt_comm_ok = '1;
    o_mf_in = '0;
    o_fault_reset = 1'b0;
    o_motor_speed = 16'h0000;
  end

  // New levels land just after a rising edge
  task automatic drive(input dtm_sense_t s, input logic [NUM_MF-1:0] mf, input logic [15:0] v);
    o_sense <= s;
    o_mf_in <= mf;
    o_motor_speed <= v;
  endtask : drive

  // Held three cycles so the synchroniser cannot miss it
  task automatic pulse_reset();
    o_fault_reset <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_fault_reset <= 1'b0;
  endtask : pulse_reset
endmodule : dtm_plant_model

/* File: verif/dtm_trip_manager_test.sv */
`timescale 1ns/1ps
// Self-checking bench for the trip manager
module dtm_trip_manager_test;
  import dtm_pkg::*;
  localparam int MS = 4;
  localparam int OLT = 120;
  localparam int NI = 17;
  localparam int TRIP_OF [NI] = '{2, 3, 4, 6, 7, 0, 1, 5, 12, 14, 15, 16, 18, 9, 10, 13, 8};
  localparam logic [15:0] ARM [NI] = '{16'h0, 16'h0, 16'h0, 16'h2, 16'h4, 16'h200, 16'h400,
    16'h800, 16'h0, 16'h1000, 16'h2000, 16'h0, 16'h20, 16'h0, 16'h0, 16'h0, 16'h0};
  localparam logic [15:0] DIS [NI] = '{16'h0, 16'h0, 16'h0, 16'h4, 16'h2, 16'h0, 16'h0,
    16'h0, 16'h80, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  logic i_clk, i_reset, avs_read, avs_write, waitreq, held, blocked, fault_reset;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, readdata, rd;
  logic [NUM_MF-1:0] mf_in;
  logic [15:0] speed;
  logic [NUM_OPT-1:0] fit, comm;
  dtm_sense_t sense;
  dtm_trips_t trips;
  dtm_hist_t hist;
  int n_fail = 0;
  int comparisons = 0;
  int n_hist = 0;
  int h0;

  dtm_plant_model plant (.i_clk(i_clk), .o_sense(sense), .o_mf_in(mf_in),
    .o_fault_reset(fault_reset), .o_motor_speed(speed));

  dtm_trip_manager #(.P_MS_CYCLES(MS), .P_OLT_LIMIT(OLT)) dut (.i_clk(i_clk),
    .i_reset(i_reset), .i_sense(sense), .i_mf_in(mf_in), .i_fault_reset(fault_reset),
    .i_motor_speed(speed), .i_avs_address(avs_address), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .o_avs_readdata(readdata),
    .o_avs_waitrequest(waitreq), .o_trips(trips), .o_fault_held(held),
    .o_output_block(blocked), .o_hist(hist));

  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Count history entries as they appear
  always @(posedge i_clk) begin
    if (hist.valid === 1'b1) n_hist <= n_hist + 1;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic chk_bit(input int i, input logic e);
    check({31'h0, trips[i]}, {31'h0, e});
  endtask : chk_bit

  // Bounded wait for one trip bit; running out ends the run
  task automatic wait_bit(input int i, input logic e, input int b);
    int n;
    n = 0;
    while (n < b && trips[i] !== e) begin
      @(posedge i_clk);
      n++;
    end
    chk_bit(i, e);
    if (trips[i] !== e) final_report();
  endtask : wait_bit

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    rd = readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (waitreq !== 1'b0) begin
      check(32'h0, 32'h1);
      final_report();
    end
    @(posedge i_clk);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    check(rd, e);
  endtask : rd_chk

  // Raise or drop the cause behind table item k
  task automatic apply(input int k, input logic on);
    dtm_sense_t s;
    logic [NUM_MF-1:0] mf;
    logic [15:0] v;
    s = '0;
    s.keypad_link_ok = 1'b1;
    s.opt_present = fit;
    s.opt_comm_ok = comm;
    mf = '0;
    v = 16'h0000;
    case (k)
      0: s.over_current = on;
      1: s.bus_over = on;
      2: s.bus_under = on;
      3: s.out_phase_loss = on;
      4: s.in_phase_loss = on;
      5: s.motor_overload = on;
      6: s.motor_underload = on;
      7: s.thermal_over = on;
      8: s.fan_fault = on;
      9: s.speed_dev = on;
      10: s.encoder_abn = on;
      11: {s.pid_below, s.pre_pid_run} = {on, on};
      12: s.cmd_lost = on;
      13: mf[0] = on;
      14: mf[1] = on;
      15: v = on ? 16'h0065 : 16'h0000;
      16: s.cur_above_200 = on;
      17: s.nvm_fault = on;
      18: s.adc_fault = on;
      19: s.wdog1 = on;
      20: s.wdog2 = on;
      21: s.cur_above_150 = on;
      22: s.keypad_link_ok = ~on;
      default: ;
    endcase
    plant.drive(s, mf, v);
  endtask : apply

  // Clear latched trips by pin and by register in turn
  task automatic recover();
    for (int n = 0; n < 600 && trips !== '0; n++) begin
      if (n % 2 == 1) wr(ADDR_CTRL, 32'h1);
      else plant.pulse_reset();
      repeat (4) @(posedge i_clk);
    end
    check(32'(trips), 32'h0);
    if (trips !== '0) final_report();
  endtask : recover

  task automatic do_reset();
    i_reset <= 1'b1;
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
  endtask : do_reset

  // Main sequence
  initial begin
    i_reset = 1'b1;
    {avs_read, avs_write} = 2'b00;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    fit = '0;
    comm = '1;
    do_reset();
    rd_chk(ADDR_CFG, 32'h0);
    rd_chk(ADDR_OVERSPEED, 32'h0000ffff);
    rd_chk(ADDR_ENC_TIME, 32'h000003e8);
    rd_chk(ADDR_PID_TIME, 32'h000003e8);
    wr(ADDR_TRIPS, 32'hffffffff);
    rd_chk(ADDR_TRIPS, 32'h0);
    wr(6'h24, 32'hffffffff);
    rd_chk(6'h24, 32'h0);
    wr(ADDR_CFG, 32'hffffffff);
    rd_chk(ADDR_CFG, 32'h00007fff);
    wr(ADDR_CFG, 32'h0);
    wr(ADDR_OVERSPEED, 32'h64);
    wr(ADDR_ENC_TIME, 32'h0);
    wr(ADDR_PID_TIME, 32'h0);
    wr(ADDR_MF_LO, 32'h43);
    // Drive overload at 150%: full limit of ticks
    apply(21, 1'b1);
    repeat ((OLT - 10) * MS) @(posedge i_clk);
    chk_bit(T_DRIVE_OLT, 1'b0);
    wait_bit(T_DRIVE_OLT, 1'b1, 20 * MS + 8);
    apply(21, 1'b0);
    recover();
    // Keypad link loss with keypad as source
    wr(ADDR_CFG, 32'h4008);
    apply(22, 1'b1);
    repeat ((KEYPAD_LOSS_MS - 10) * MS) @(posedge i_clk);
    chk_bit(T_LOST_KEYPAD, 1'b0);
    wait_bit(T_LOST_KEYPAD, 1'b1, 20 * MS + 8);
    apply(22, 1'b0);
    wait_bit(T_LOST_KEYPAD, 1'b0, 12);
    // Each cause, first disarmed where it has an arm setting, then armed
    for (int k = 0; k < NI; k++) begin
      if (DIS[k] != ARM[k]) begin
        wr(ADDR_CFG, {16'h0, DIS[k]});
        apply(k, 1'b1);
        repeat (12) @(posedge i_clk);
        chk_bit(TRIP_OF[k], 1'b0);
      end
      h0 = n_hist;
      wr(ADDR_CFG, {16'h0, ARM[k]});
      apply(k, 1'b1);
      wait_bit(TRIP_OF[k], 1'b1, 40);
      @(posedge i_clk);
      check({31'h0, blocked}, 32'h1);
      check({31'h0, held}, {31'h0, LATCH_MASK[TRIP_OF[k]]});
      if (LATCH_MASK[TRIP_OF[k]]) begin
        check(32'(n_hist - h0), 32'h1);
        check(32'(hist.code), 32'(TRIP_OF[k]));
        rd_chk(ADDR_LAST, 32'(TRIP_OF[k]));
        wr(ADDR_CTRL, 32'h1);
        apply(k, 1'b0);
        repeat (12) @(posedge i_clk);
        chk_bit(TRIP_OF[k], 1'b1);
        recover();
      end else begin
        check(32'(n_hist - h0), 32'h0);
        apply(k, 1'b0);
        wait_bit(TRIP_OF[k], 1'b0, 12);
      end
      wr(ADDR_CFG, 32'h0);
    end
    // Option slots: removal after fitting, then link loss
    for (int s = 0; s < NUM_OPT; s++) begin
      fit[s] = 1'b1;
      apply(99, 1'b0);
      repeat (8) @(posedge i_clk);
      chk_bit(T_OPT1 + s, 1'b0);
      fit[s] = 1'b0;
      apply(99, 1'b0);
      wait_bit(T_OPT1 + s, 1'b1, 12);
      fit[s] = 1'b1;
      apply(99, 1'b0);
      wait_bit(T_OPT1 + s, 1'b0, 12);
      comm[s] = 1'b0;
      apply(99, 1'b0);
      wait_bit(T_OPT1 + s, 1'b1, 12);
      comm[s] = 1'b1;
      apply(99, 1'b0);
      wait_bit(T_OPT1 + s, 1'b0, 12);
    end
    // Diagnostic faults survive fault reset, cleared only by power-up
    for (int k = 17; k < 21; k++) begin
      apply(k, 1'b1);
      wait_bit(T_HW_DIAG, 1'b1, 12);
      apply(k, 1'b0);
      wr(ADDR_CTRL, 32'h1);
      plant.pulse_reset();
      repeat (8) @(posedge i_clk);
      chk_bit(T_HW_DIAG, 1'b1);
      do_reset();
      chk_bit(T_HW_DIAG, 1'b0);
    end
    final_report();
  end
endmodule : dtm_trip_manager_test
